/* File: hw/spgc_top.sv */
// Purpose: gpio control of the serial data and clock pins, apb register port
// Assumes: pad ring resolves the pins; open-drain pads ignore pad_out high
// Notes:   zero-wait apb slave; pready always high
//
// Functional notes
// - direction bit 1: data pin input at 0, output at 1
// - direction bit 0: clock pin input at 0, output at 1
// - level bit 1 shows data pin level, whatever the mode
// - level bit 0 shows clock pin level, whatever the mode
// - level register is read-only; writes do nothing
// - pin levels pass through a synchroniser into pclk domain
// - output value holds and reads back; direction/function writes leave it
// - pin driven only by the serial engine, or in gpio mode with its direction bit at 1
// - output bit 1 sets the data pin level
// - output bit 0 sets the clock pin level
// - in gpio mode open-drain pads drive only low; high is released
// - output value reads return stored bits, not pin levels
// - set alias: ones set output bits, zeros leave them
// - clear alias: ones clear output bits, zeros leave them
// - clear bit 1 acts on data pin, bit 0 on clock pin
// - set alias bit 0 acts on data pin, bit 1 on clock pin
// - set and clear aliases read back undefined; here zero
// - bits 31-2 read zero and ignore writes
// - function bit 0: 0 serial engine owns pins, 1 gpio
// - in gpio mode the serial engine sees 1 on both inputs
module spgc_top
  import spgc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  pad_in,
  output logic      [1:0]  pad_out,
  output logic      [1:0]  pad_oe,
  input  wire logic [1:0]  pad_open_drain,
  input  wire logic [1:0]  engine_out,
  input  wire logic [1:0]  engine_oe,
  output logic      [1:0]  engine_in
);

  spgc_regs_t state;
  spgc_regs_t next_state;
  logic [1:0] pin_sync;
  logic       wr_en;
  logic       wr_low;
  logic [1:0] set_bits;
  logic       known;
  spgc_pad_t  pad;

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  spgc_sync #(
    .WIDTH (2)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pad_in),
    .sync_out (pin_sync)
  );

  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  // only the low byte holds live bits, so only its strobe matters
  assign wr_low  = wr_en && pstrb[0];
  assign known   = addr_is(paddr, SPGC_OFF_FUNC) || addr_is(paddr, SPGC_OFF_DIR)
                || addr_is(paddr, SPGC_OFF_DIN)  || addr_is(paddr, SPGC_OFF_DOUT)
                || addr_is(paddr, SPGC_OFF_DSET) || addr_is(paddr, SPGC_OFF_DCLR);
  assign pslverr = psel && penable && !known;

  // set alias is wired crosswise to the output bits
  assign set_bits[SPGC_BIT_DATA]  = pwdata[SPGC_SET_DATA];
  assign set_bits[SPGC_BIT_CLOCK] = pwdata[SPGC_SET_CLOCK];

  always_comb begin
    next_state     = state;
    next_state.din = pin_sync;
    if (wr_low) begin
      if (addr_is(paddr, SPGC_OFF_FUNC)) begin
        next_state.func = pwdata[SPGC_BIT_FUNC];
      end
      if (addr_is(paddr, SPGC_OFF_DIR)) begin
        next_state.dir = pwdata[1:0];
      end
      if (addr_is(paddr, SPGC_OFF_DOUT)) begin
        next_state.dout = pwdata[1:0];
      end
      if (addr_is(paddr, SPGC_OFF_DSET)) begin
        next_state.dout = state.dout | set_bits;
      end
      if (addr_is(paddr, SPGC_OFF_DCLR)) begin
        next_state.dout = state.dout & ~pwdata[1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state.func <= SPGC_RST_FUNC;
      state.dir  <= SPGC_RST_DIR;
      state.dout <= SPGC_RST_DOUT;
      state.din  <= SPGC_RST_SYNC;
    end else begin
      state <= next_state;
    end
  end

  // read data from flops of state; level register ignores writes
  always_comb begin
    prdata = 32'h00000000;
    if (addr_is(paddr, SPGC_OFF_FUNC)) begin
      prdata[SPGC_BIT_FUNC] = state.func;
    end else if (addr_is(paddr, SPGC_OFF_DIR)) begin
      prdata[1:0] = state.dir;
    end else if (addr_is(paddr, SPGC_OFF_DIN)) begin
      prdata[1:0] = state.din;
    end else if (addr_is(paddr, SPGC_OFF_DOUT)) begin
      prdata[1:0] = state.dout;
    end else begin
      prdata = SPGC_ALIAS_READ;
    end
  end

  // pad mux; gpio outputs are the dir/dout flops gated by pad_open_drain, then muxed with the engine by func
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (state.func) begin
        pad.oe[i]  = state.dir[i] && !(pad_open_drain[i] && state.dout[i]);
        pad.out[i] = state.dout[i] && !pad_open_drain[i];
      end else begin
        pad.oe[i]  = engine_oe[i];
        pad.out[i] = engine_out[i];
      end
    end
  end

  assign pad_oe    = pad.oe;
  assign pad_out   = pad.out;
  assign engine_in = state.func ? 2'h3 : pin_sync;

  a_set_alias_map : assert property (@(posedge pclk) disable iff (!presetn)
    (wr_low && addr_is(paddr, SPGC_OFF_DSET) && pwdata[SPGC_SET_DATA])
      |=> state.dout[SPGC_BIT_DATA])
    else $error("set alias bit 0 did not set data pin output");

  a_clear_alias_map : assert property (@(posedge pclk) disable iff (!presetn)
    (wr_low && addr_is(paddr, SPGC_OFF_DCLR) && pwdata[SPGC_BIT_CLOCK])
      |=> !state.dout[SPGC_BIT_CLOCK])
    else $error("clear alias bit 0 did not clear clock pin output");

  a_dout_holds : assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && (addr_is(paddr, SPGC_OFF_DIR) || addr_is(paddr, SPGC_OFF_FUNC)
      || addr_is(paddr, SPGC_OFF_DIN))) |=> $stable(state.dout))
    else $error("output value changed on unrelated write");

  a_drive_gate : assert property (@(posedge pclk) disable iff (!presetn)
    (state.func && !state.dir[SPGC_BIT_DATA]) |-> !pad_oe[SPGC_BIT_DATA])
    else $error("data pin driven while input");

  a_open_drain : assert property (@(posedge pclk) disable iff (!presetn)
    (state.func && pad_open_drain[SPGC_BIT_CLOCK] && state.dout[SPGC_BIT_CLOCK])
      |-> !pad_oe[SPGC_BIT_CLOCK])
    else $error("open-drain clock pin driven high");

  a_level_latency : assert property (@(posedge pclk) disable iff (!presetn)
    ##3 (state.din == $past(pad_in, 3)))
    else $error("pin level register lags wrong");

  a_engine_ones : assert property (@(posedge pclk) disable iff (!presetn)
    state.func |-> engine_in == 2'h3)
    else $error("engine not isolated in gpio mode");

  a_reserved_zero : assert property (@(posedge pclk) disable iff (!presetn)
    prdata[31:2] == 30'h0)
    else $error("reserved bits read nonzero");

  a_drive_value : assert property (@(posedge pclk) disable iff (!presetn)
    (state.func && pad_oe[SPGC_BIT_DATA]) |-> pad_out[SPGC_BIT_DATA] == state.dout[SPGC_BIT_DATA])
    else $error("data pin drives wrong level");

  // write strobes for each register, one access-phase edge each
  // a write only counts when the low byte strobe is on

  sequence s_wr_func;
    wr_low && addr_is(paddr, SPGC_OFF_FUNC);
  endsequence

  sequence s_wr_dir;
    wr_low && addr_is(paddr, SPGC_OFF_DIR);
  endsequence

  sequence s_wr_dout;
    wr_low && addr_is(paddr, SPGC_OFF_DOUT);
  endsequence

  sequence s_wr_set;
    wr_low && addr_is(paddr, SPGC_OFF_DSET);
  endsequence

  sequence s_wr_clr;
    wr_low && addr_is(paddr, SPGC_OFF_DCLR);
  endsequence

  sequence s_wr_level;
    wr_en && addr_is(paddr, SPGC_OFF_DIN);
  endsequence

  sequence s_wr_no_strobe;
    wr_en && !pstrb[0];
  endsequence

  // register updates

  a_func_write : assert property (@(posedge pclk) disable iff (!presetn)
    s_wr_func
      |=> state.func == $past(pwdata[SPGC_BIT_FUNC]))
    else $error("function select write not taken");

  a_dir_write : assert property (@(posedge pclk) disable iff (!presetn)
    s_wr_dir
      |=> state.dir == $past(pwdata[1:0]))
    else $error("direction write not taken");

  a_dout_write : assert property (@(posedge pclk) disable iff (!presetn)
    s_wr_dout
      |=> state.dout == $past(pwdata[1:0]))
    else $error("output value write not taken");

  a_level_readonly : assert property (@(posedge pclk) disable iff (!presetn)
    s_wr_level
      |=> state.din == $past(pin_sync))
    else $error("level register took a write");

  a_strobe_gate : assert property (@(posedge pclk) disable iff (!presetn)
    s_wr_no_strobe
      |=> $stable(state.dout) && $stable(state.dir) && $stable(state.func))
    else $error("write without low strobe changed a register");

  // set and clear aliases; zeros must leave the other bit alone

  a_set_clock_map : assert property (@(posedge pclk) disable iff (!presetn)
    (s_wr_set ##0 pwdata[SPGC_SET_CLOCK])
      |=> state.dout[SPGC_BIT_CLOCK])
    else $error("set alias bit 1 did not set clock pin output");

  a_set_keeps_zero : assert property (@(posedge pclk) disable iff (!presetn)
    (s_wr_set ##0 !pwdata[SPGC_SET_CLOCK])
      |=> $stable(state.dout[SPGC_BIT_CLOCK]))
    else $error("set alias zero changed clock pin output");

  a_clear_data_map : assert property (@(posedge pclk) disable iff (!presetn)
    (s_wr_clr ##0 pwdata[SPGC_BIT_DATA])
      |=> !state.dout[SPGC_BIT_DATA])
    else $error("clear alias bit 1 did not clear data pin output");

  a_clear_keeps_zero : assert property (@(posedge pclk) disable iff (!presetn)
    (s_wr_clr ##0 !pwdata[SPGC_BIT_DATA])
      |=> $stable(state.dout[SPGC_BIT_DATA]))
    else $error("clear alias zero changed data pin output");

  // pad drive in gpio use

  a_drive_gate_clock : assert property (@(posedge pclk) disable iff (!presetn)
    (state.func && !state.dir[SPGC_BIT_CLOCK])
      |-> !pad_oe[SPGC_BIT_CLOCK])
    else $error("clock pin driven while input");

  a_clock_value : assert property (@(posedge pclk) disable iff (!presetn)
    (state.func && pad_oe[SPGC_BIT_CLOCK])
      |-> pad_out[SPGC_BIT_CLOCK] == state.dout[SPGC_BIT_CLOCK])
    else $error("clock pin drives wrong level");

  a_open_drain_data : assert property (@(posedge pclk) disable iff (!presetn)
    (state.func && pad_open_drain[SPGC_BIT_DATA] && state.dout[SPGC_BIT_DATA])
      |-> !pad_oe[SPGC_BIT_DATA])
    else $error("open-drain data pin driven high");

  a_push_pull_high : assert property (@(posedge pclk) disable iff (!presetn)
    (state.func && state.dir[SPGC_BIT_DATA] && !pad_open_drain[SPGC_BIT_DATA] && state.dout[SPGC_BIT_DATA])
      |-> pad_oe[SPGC_BIT_DATA] && pad_out[SPGC_BIT_DATA])
    else $error("push-pull data pin not driven high");

  // engine mode hands the pads over untouched

  a_engine_pass : assert property (@(posedge pclk) disable iff (!presetn)
    !state.func
      |-> pad_oe == engine_oe && pad_out == engine_out)
    else $error("engine mode pads not passed through");

  a_engine_sees_pins : assert property (@(posedge pclk) disable iff (!presetn)
    !state.func
      |-> engine_in == pin_sync)
    else $error("engine does not see pin levels");

  // read side

  a_read_dout : assert property (@(posedge pclk) disable iff (!presetn)
    (psel && addr_is(paddr, SPGC_OFF_DOUT))
      |-> prdata[1:0] == state.dout)
    else $error("output value read not from register");

  a_read_level : assert property (@(posedge pclk) disable iff (!presetn)
    (psel && addr_is(paddr, SPGC_OFF_DIN))
      |-> prdata[1:0] == state.din)
    else $error("level read not from synchronised pins");

  a_alias_read : assert property (@(posedge pclk) disable iff (!presetn)
    (psel && (addr_is(paddr, SPGC_OFF_DSET) || addr_is(paddr, SPGC_OFF_DCLR)))
      |-> prdata == SPGC_ALIAS_READ)
    else $error("alias read not zero");

  a_unmapped_err : assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !known)
      |-> pslverr)
    else $error("unmapped access without error");

  a_mapped_ok : assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && known)
      |-> !pslverr && pready)
    else $error("mapped access flagged or stalled");

endmodule // spgc_top

/* File: hw/spgc_pkg.sv */
// Purpose: shared constants and types for the serial pin gpio control block
// Assumes: apb slave, 32-bit data, one word per register
// Notes:   offsets are byte addresses
package spgc_pkg;

  localparam logic [11:0] SPGC_OFF_FUNC   = 12'h000;
  localparam logic [11:0] SPGC_OFF_DIR    = 12'h004;
  localparam logic [11:0] SPGC_OFF_DIN    = 12'h008;
  localparam logic [11:0] SPGC_OFF_DOUT   = 12'h00C;
  localparam logic [11:0] SPGC_OFF_DSET   = 12'h010;
  localparam logic [11:0] SPGC_OFF_DCLR   = 12'h014;

  localparam int          SPGC_BIT_DATA   = 1;
  localparam int          SPGC_BIT_CLOCK  = 0;
  localparam int          SPGC_SET_DATA   = 0;
  localparam int          SPGC_SET_CLOCK  = 1;
  localparam int          SPGC_BIT_FUNC   = 0;

  localparam logic [1:0]  SPGC_RST_DIR    = 2'h0;
  localparam logic [1:0]  SPGC_RST_DOUT   = 2'h0;
  localparam logic        SPGC_RST_FUNC   = 1'h0;
  localparam logic [1:0]  SPGC_RST_SYNC   = 2'h3;
  localparam logic [31:0] SPGC_ALIAS_READ = 32'h00000000;

  typedef struct packed {
    logic       func;
    logic [1:0] dir;
    logic [1:0] dout;
    logic [1:0] din;
  } spgc_regs_t;

  typedef struct packed {
    logic [1:0] oe;
    logic [1:0] out;
  } spgc_pad_t;

endpackage

/* File: hw/spgc_sync.sv */
// Purpose: two-flop synchroniser for the pin levels
// Assumes: inputs may change at any time
// Notes:   first stage is read only by the second stage
module spgc_sync
  import spgc_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1   <= WIDTH'(SPGC_RST_SYNC);
      sync_out <= WIDTH'(SPGC_RST_SYNC);
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // spgc_sync

/* File: tb/spgc_board.sv */
// Purpose: board nets on the serial data and clock pins
// Assumes: pull-ups on both nets; other devices can only pull low
// Notes:   a low from any driver wins, so a push-pull fight reads low
module spgc_board (
  input  wire logic [1:0] pad_out,
  input  wire logic [1:0] pad_oe,
  input  wire logic [1:0] ext_low,
  output logic      [1:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // released net floats up to the pull-up level, never keeps the old value
  assign pad_in = ~((pad_oe & ~pad_out) | ext_low);
endmodule // spgc_board

/* File: tb/tb.sv */
// Purpose: self-checking bench for the serial pin gpio control block
// Assumes: zero-wait apb slave, board nets with pull-ups
// Notes:   expectations come from a shadow copy of the registers
module tb
  import spgc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, m_func;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, v;
  logic [3:0]  pstrb, xp;
  logic [1:0]  pad_in, pad_out, pad_oe, pad_open_drain, engine_out, engine_oe, engine_in, ext_low, m_dir, m_dout;
  int          n_mismatch, n_compared, cyc;

  spgc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .pad_in, .pad_out, .pad_oe, .pad_open_drain, .engine_out, .engine_oe, .engine_in);
  spgc_board board (.pad_out, .pad_oe, .ext_low, .pad_in);

  task automatic stop_test();
    if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic err);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("unexpected at %0t: no pready within 20 cycles", $time);
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x);
    chk({31'h0, e}, 32'h0);
  endtask

  // expected {pad_oe, pad_out}: in gpio mode open-drain pads only ever pull low; engine mode passes engine_oe/engine_out
  function automatic logic [3:0] pads();
    logic [1:0] g;
    logic [1:0] f;
    f = {2{m_func}};
    g = f & m_dir;
    return {(g & ~(pad_open_drain & m_dout)) | (~f & engine_oe), (f & m_dout & ~pad_open_drain) | (~f & engine_out)};
  endfunction

  function automatic logic [1:0] lvl(input logic [3:0] p);
    return ~((p[3:2] & ~p[1:0]) | ext_low);
  endfunction

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // generous ceiling: the whole run needs about 1550 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {pad_open_drain, engine_out, engine_oe, ext_low} = 8'h0;
    pstrb = 4'hF;
    presetn = 1'b0;
    {cyc, n_mismatch, n_compared} = '0;
    v = $urandom(32'h9E33);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    {m_func, m_dir, m_dout} = 5'h0;
    rd(SPGC_OFF_DIR, 32'h0);
    rd(SPGC_OFF_DOUT, 32'h0);
    for (int i = 0; i < 40; i++) begin
      @(posedge pclk);
      {pad_open_drain, engine_out, engine_oe, ext_low} <= 8'($urandom);
      v = $urandom;
      wr(SPGC_OFF_DOUT, v);
      m_dout = v[1:0];
      v = $urandom;
      wr(SPGC_OFF_FUNC, v);
      m_func = v[0];
      v = $urandom;
      wr(SPGC_OFF_DIR, v);
      m_dir = v[1:0];
      wr(SPGC_OFF_DIN, $urandom);
      v = $urandom;
      wr(SPGC_OFF_DSET, v);
      m_dout = m_dout | {v[0], v[1]};
      v = $urandom;
      wr(SPGC_OFF_DCLR, v);
      m_dout = m_dout & ~v[1:0];
      repeat (4) @(posedge pclk);
      xp = pads();
      chk({28'h0, pad_oe, pad_out}, {28'h0, xp});
      rd(SPGC_OFF_DIR, {30'h0, m_dir});
      rd(SPGC_OFF_DOUT, {30'h0, m_dout});
      rd(SPGC_OFF_DIN, {30'h0, lvl(xp)});
      rd(SPGC_OFF_DSET, 32'h0);
      rd(SPGC_OFF_DCLR, 32'h0);
      chk({30'h0, engine_in}, {30'h0, m_func ? 2'h3 : lvl(xp)});
    end
    // a write with its low byte strobe off must leave the output value
    @(posedge pclk);
    pstrb <= 4'h0;
    wr(SPGC_OFF_DOUT, {30'h0, ~m_dout});
    pstrb <= 4'hF;
    rd(SPGC_OFF_DOUT, {30'h0, m_dout});
    apb(1'b0, 12'h018, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    stop_test();
  end
endmodule // tb
